// >>> src/cms_clkdiv.sv
/*
 * Control clock tick generator: half-rate low clock and 1/64, 1/128 high-speed dividers.
 * Assumes the low-speed and oscillator clocks arrive as one-cycle enables on clk.
 */
`timescale 1ns/1ps
module cms_clkdiv
    import cms_pkg::*;
#(
    parameter int unsigned DIV_LO = OSC_DIV_LO,
    parameter int unsigned DIV_HI = OSC_DIV_HI
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       ls_tick,
    input  wire logic       osc_tick,
    input  wire logic       ck_sel,
    input  wire logic [1:0] sm_sel,
    output logic            ctl_tick
);
    localparam int unsigned LO_W = $clog2(DIV_LO);
    localparam int unsigned HI_W = $clog2(DIV_HI);

    if (DIV_LO < 2 || (1 << LO_W) != DIV_LO || (1 << HI_W) != DIV_HI || DIV_HI <= DIV_LO) begin
        $error("cms_clkdiv: dividers must be powers of two with DIV_HI above DIV_LO");
    end

    logic            half_ff;
    logic [HI_W-1:0] osc_cnt_ff;
    logic            ctl_tick_ff;

    wire logic tick_half = ls_tick & half_ff;
    wire logic tick_lo   = osc_tick & (&osc_cnt_ff[LO_W-1:0]);
    wire logic tick_hi   = osc_tick & (&osc_cnt_ff);

    wire logic nxt_tick  = !ck_sel ? (sm_sel[0] ? tick_half : ls_tick)
                                   : ((sm_sel == 2'h3) ? tick_hi : tick_lo);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            half_ff     <= 1'b0;
            osc_cnt_ff  <= '0;
            ctl_tick_ff <= 1'b0;
        end else begin
            if (ls_tick) begin
                half_ff <= ~half_ff;
            end
            if (osc_tick) begin
                osc_cnt_ff <= osc_cnt_ff + 1'b1;
            end
            ctl_tick_ff <= nxt_tick;
        end
    end

    assign ctl_tick = ctl_tick_ff;

endmodule

// >>> src/cms_pkg.sv
/*
 * Constants, field layout, state codes and delay lookup for the comparator mode sequencer.
 * Assumes a single 200 MHz system clock, with the slow clocks arriving as one-cycle enables.
 */
package cms_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 16;

    localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
    localparam logic [ADDR_W-1:0] MODE_OFS = 4'h2;

    localparam int unsigned EN_BIT   = 0;
    localparam int unsigned RES_BIT  = 1;
    localparam int unsigned VLD_BIT  = 2;
    localparam int unsigned IRQ_LSB  = 0;
    localparam int unsigned MD_LSB   = 4;
    localparam int unsigned SM_LSB   = 8;
    localparam int unsigned CK_BIT   = 12;

    localparam logic [DATA_W-1:0] MODE_MASK = 16'h1333;
    localparam logic [DATA_W-1:0] MODE_RST  = 16'h0020;
    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;

    localparam logic [1:0] MD_SINGLE  = 2'h0;
    localparam logic [1:0] MD_MONITOR = 2'h1;

    localparam logic [1:0] IRQ_NONE = 2'h0;
    localparam logic [1:0] IRQ_LOW  = 2'h1;
    localparam logic [1:0] IRQ_HIGH = 2'h2;
    localparam logic [1:0] IRQ_BOTH = 2'h3;

    localparam int unsigned LS_DIV     = 2;
    localparam int unsigned OSC_DIV_LO = 64;
    localparam int unsigned OSC_DIV_HI = 128;

    localparam int unsigned CNT_W = 3;
    localparam logic [CNT_W-1:0] RDY_LS     = 3'h2;
    localparam logic [CNT_W-1:0] RDY_LS_SMP = 3'h3;
    localparam logic [CNT_W-1:0] RDY_HS     = 3'h3;
    localparam logic [CNT_W-1:0] RDY_HS_SMP = 3'h4;
    localparam logic [CNT_W-1:0] RDY_HS_SLO = 3'h3;
    localparam logic [CNT_W-1:0] CNT_ONE    = 3'h1;
    localparam logic [CNT_W-1:0] CNT_ZERO   = 3'h0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RDY  = 4'h2,
        ST_RUN  = 4'h4,
        ST_END  = 4'h8
    } cms_state_t;

    // Ready delay in control ticks for each clock and sampling choice.
    function automatic logic [CNT_W-1:0] cms_rdy_ticks(input logic ck, input logic [1:0] sm);
        logic [CNT_W-1:0] r;
        r = RDY_LS;
        if (!ck) begin
            r = sm[0] ? RDY_LS_SMP : RDY_LS;
        end else if (!sm[1]) begin
            r = RDY_HS;
        end else begin
            r = sm[0] ? RDY_HS_SLO : RDY_HS_SMP;
        end
        return r;
    endfunction

    // Sampling is on for the half-rate low clock and both sampled high-speed settings.
    function automatic logic cms_sampled(input logic ck, input logic [1:0] sm);
        return ck ? sm[1] : sm[0];
    endfunction

endpackage

// >>> src/cms_top.sv
/*
 * Comparator mode sequencer: supervisor, single and single monitor modes with register port.
 * Assumes inputs synchronous to clk except the raw comparator output, which is synchronised.
 */
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module cms_top
    import cms_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic              low_speed_clock,
    input  wire logic              high_speed_osc_clock,
    input  wire logic              raw_comparator_output,
    output logic                   compare_interrupt,
    output logic                   trigger_output
);
    logic              sync1_ff;
    logic              sync2_ff;
    logic [DATA_W-1:0] mode_ff;
    logic              en_ff;
    logic              res_ff;
    logic              vld_ff;
    logic [CNT_W-1:0]  cnt_ff;
    cms_state_t        state_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              irq_ff;
    logic              tgo_ff;
    logic              ctl_tick;

    cms_state_t        nxt_state;
    logic              nxt_en;
    logic              nxt_res;
    logic              nxt_vld;
    logic [CNT_W-1:0]  nxt_cnt;
    logic              nxt_irq;

    wire logic [1:0] irq_code = mode_ff[IRQ_LSB +: 2];
    wire logic [1:0] md       = mode_ff[MD_LSB +: 2];
    wire logic [1:0] sm       = mode_ff[SM_LSB +: 2];
    wire logic       ck       = mode_ff[CK_BIT];

    wire logic is_sup     = md[1];
    wire logic is_single  = (md == MD_SINGLE);
    wire logic is_monitor = (md == MD_MONITOR);

    wire logic wr_ctrl = wr & (addr == CTRL_OFS);
    wire logic wr_mode = wr & (addr == MODE_OFS);
    wire logic busy    = (state_ff != ST_IDLE);

    wire logic [CNT_W-1:0] rdy_n = cms_rdy_ticks(ck, sm);
    // Sampled settings update only on ticks.
    wire logic sample_en = cms_sampled(ck, sm) ? ctl_tick : 1'b1;

    wire logic reach_rdy = (state_ff == ST_RDY) & ctl_tick & (cnt_ff == rdy_n - CNT_ONE);
    // End delay one tick after ready.
    wire logic reach_end = (state_ff == ST_END) & ctl_tick;

    // A software set in the same cycle as the hardware clear restarts the measurement.
    wire logic start = wr_ctrl & wdata[EN_BIT] & (~busy | reach_end);
    wire logic abort = wr_ctrl & ~wdata[EN_BIT] & busy;

    wire logic res_chg = (sync2_ff != res_ff);

    // Start condition for the selected supervisor code.
    wire logic sup_start_hit = ((irq_code == IRQ_LOW) & ~sync2_ff)
                             | ((irq_code == IRQ_HIGH) & sync2_ff)
                             | ((irq_code == IRQ_BOTH) & sync2_ff);
    // Change condition for the selected supervisor code.
    wire logic sup_chg_hit = res_chg
                           & (((irq_code == IRQ_LOW) & ~sync2_ff)
                           | ((irq_code == IRQ_HIGH) & sync2_ff)
                           | (irq_code == IRQ_BOTH));
    // Single mode match on upper code bit.
    wire logic single_hit = (sync2_ff == irq_code[1]);

    wire logic tgo_pol = (irq_code == IRQ_LOW);
    wire logic nxt_tgo = is_sup & nxt_vld & (nxt_state == ST_RUN) & (nxt_res ^ tgo_pol);

    cms_clkdiv #(
        .DIV_LO(OSC_DIV_LO),
        .DIV_HI(OSC_DIV_HI)
    ) u_clkdiv (
        .clk     (clk),
        .nrst    (nrst),
        .ls_tick (low_speed_clock),
        .osc_tick(high_speed_osc_clock),
        .ck_sel  (ck),
        .sm_sel  (sm),
        .ctl_tick(ctl_tick)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_en    = en_ff;
        nxt_res   = res_ff;
        nxt_vld   = vld_ff;
        nxt_cnt   = cnt_ff;
        nxt_irq   = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                nxt_cnt = CNT_ZERO;
            end
            ST_RDY: begin
                if (ctl_tick) begin
                    nxt_cnt = cnt_ff + CNT_ONE;
                end
                // Valid and result load at ready.
                if (reach_rdy) begin
                    nxt_vld = 1'b1;
                    nxt_res = sync2_ff;
                    if (is_sup) begin
                        nxt_state = ST_RUN;
                        nxt_irq   = sup_start_hit;
                    end else begin
                        nxt_state = ST_END;
                        nxt_irq   = is_single & single_hit;
                    end
                end
            end
            ST_RUN: begin
                if (sample_en) begin
                    nxt_res = sync2_ff;
                    nxt_irq = sup_chg_hit;
                end
            end
            ST_END: begin
                if (reach_end) begin
                    nxt_en    = 1'b0;
                    nxt_state = ST_IDLE;
                    nxt_irq   = is_monitor;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_en    = 1'b0;
            end
        endcase
        if (abort) begin
            nxt_en    = 1'b0;
            nxt_state = ST_IDLE;
            nxt_irq   = is_monitor;
        end
        if (start) begin
            nxt_en    = 1'b1;
            nxt_vld   = 1'b0;
            nxt_cnt   = CNT_ZERO;
            nxt_state = ST_RDY;
            nxt_irq   = 1'b0;
        end
        if (is_monitor & busy & ~reach_end & ~abort) begin
            nxt_irq = 1'b0;
        end
    end

    wire logic [DATA_W-1:0] ctrl_word = {{(DATA_W-3){1'b0}}, vld_ff, res_ff, en_ff};
    wire logic [DATA_W-1:0] rd_word   = (addr == CTRL_OFS) ? ctrl_word
                                      : (addr == MODE_OFS) ? (mode_ff & MODE_MASK)
                                      : ZERO_WORD;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= raw_comparator_output;
            sync2_ff <= sync1_ff;
        end
    end

    // Mode writes are refused while a measurement runs.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_ff <= MODE_RST;
        end else if (wr_mode & ~en_ff) begin
            mode_ff <= wdata & MODE_MASK;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= ST_IDLE;
            en_ff    <= 1'b0;
            res_ff   <= 1'b0;
            vld_ff   <= 1'b0;
            cnt_ff   <= CNT_ZERO;
            irq_ff   <= 1'b0;
            tgo_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            en_ff    <= nxt_en;
            res_ff   <= nxt_res;
            vld_ff   <= nxt_vld;
            cnt_ff   <= nxt_cnt;
            irq_ff   <= nxt_irq;
            tgo_ff   <= nxt_tgo;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= ZERO_WORD;
        end else begin
            rdata_ff <= rd ? rd_word : ZERO_WORD;
        end
    end

    assign rdata             = rdata_ff;
    assign compare_interrupt = irq_ff;
    assign trigger_output    = tgo_ff;

endmodule

// >>> tb/cms_partner.sv
/*
 * Far side model: analog comparator output and the slow clock enable pulses.
 * Assumes the bench sets the compare level; pulse periods are shortened.
 */
`timescale 1ns/1ps
module cms_partner #(
    parameter int LS_P  = 20,
    parameter int OSC_P = 4
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic level,
    output wire logic raw_out,
    output logic      ls_pulse,
    output logic      osc_pulse
);
    int ls_cnt;
    int osc_cnt;

    // Raw output moves off the clock grid.
    assign #1.3 raw_out = level;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ls_cnt    <= 0;
            osc_cnt   <= 0;
            ls_pulse  <= 1'b0;
            osc_pulse <= 1'b0;
        end else begin
            ls_cnt    <= (ls_cnt == LS_P - 1) ? 0 : ls_cnt + 1;
            osc_cnt   <= (osc_cnt == OSC_P - 1) ? 0 : osc_cnt + 1;
            ls_pulse  <= (ls_cnt == LS_P - 1);
            osc_pulse <= (osc_cnt == OSC_P - 1);
        end
    end
endmodule

// >>> tb/cms_props.sv
/*
 * Port checker for the comparator mode sequencer, bound onto cms_top.
 * Assumes one clock domain with an asynchronous active-low reset.
 */
`timescale 1ns/1ps
module cms_props
    import cms_pkg::*;
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              low_speed_clock,
    input wire logic              high_speed_osc_clock,
    input wire logic              raw_comparator_output,
    input wire logic              compare_interrupt,
    input wire logic              trigger_output
);
    logic [3:0] quiet_ff;
    logic [3:0] nxt_quiet;
    logic       raw_ff;
    logic [5:0] osc_n_ff;
    wire        cause;

    // Any event that may legally move the outputs restarts the quiet count.
    // Only every 64th oscillator pulse can become a control tick, so only that one counts.
    assign cause = low_speed_clock | (high_speed_osc_clock & (&osc_n_ff)) | wr
                 | (raw_ff != raw_comparator_output);
    assign nxt_quiet = cause ? 4'h0 : ((quiet_ff == 4'hf) ? quiet_ff : quiet_ff + 4'h1);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            quiet_ff <= 4'h0;
            raw_ff   <= 1'b0;
            osc_n_ff <= 6'h0;
        end else begin
            quiet_ff <= nxt_quiet;
            raw_ff   <= raw_comparator_output;
            if (high_speed_osc_clock) begin
                osc_n_ff <= osc_n_ff + 6'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    idle_rdata_a: assert property (
        !$past(rd) |-> rdata == ZERO_WORD) else $error("read data outside a read slot");
    unmapped_zero_a: assert property (
        rd && addr != CTRL_OFS && addr != MODE_OFS |=> rdata == ZERO_WORD)
        else $error("unmapped read returned data");
    mode_mask_a: assert property (
        rd && addr == MODE_OFS |=> (rdata & ~MODE_MASK) == ZERO_WORD)
        else $error("mode read shows unused bits");
    ctrl_upper_a: assert property (
        rd && addr == CTRL_OFS |=> rdata[DATA_W-1:3] == 13'h0)
        else $error("control read shows unused bits");
    trig_idle_a: assert property (
        rd && addr == CTRL_OFS ##1 (!rdata[EN_BIT] || !rdata[VLD_BIT]) |-> !$past(trigger_output))
        else $error("trigger while stopped or not ready");
    reset_quiet_a: assert property (
        $rose(nrst) |-> !compare_interrupt && !trigger_output && rdata == ZERO_WORD)
        else $error("outputs active after reset");
    irq_cause_a: assert property (
        compare_interrupt |-> quiet_ff < 4'h8) else $error("interrupt without a cause");
    trig_cause_a: assert property (
        $changed(trigger_output) |-> quiet_ff < 4'h8) else $error("trigger moved without a cause");
endmodule

bind cms_top cms_props u_props (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .low_speed_clock(low_speed_clock), .high_speed_osc_clock(high_speed_osc_clock),
    .raw_comparator_output(raw_comparator_output), .compare_interrupt(compare_interrupt),
    .trigger_output(trigger_output)
);

// >>> tb/test_comparator_mode_sequencer.sv
/*
 * Register-level bench for the comparator mode sequencer.
 * Assumes cms_partner supplies the comparator level and slow clock pulses.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end
module test_comparator_mode_sequencer;
    import cms_pkg::*;
    localparam int LS_P  = 20;
    localparam int OSC_P = 4;
    localparam int TMAX  = 60000;
    logic              clk, nrst, wr, rd, level, ls_clk, osc_clk, raw, irq, trig;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, d;
    int                n_errors, checked, cyc, irq_cnt, k0, t0, t, t_lo, t_hi;
    logic [2:0]        set_tab [5] = '{3'b000, 3'b001, 3'b100, 3'b110, 3'b111};
    int                n_tab [5] = '{2, 3, 3, 4, 3};
    int                p_tab [5] = '{LS_P, 2*LS_P, 64*OSC_P, 64*OSC_P, 128*OSC_P};

    cms_top DUT (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .low_speed_clock(ls_clk), .high_speed_osc_clock(osc_clk),
        .raw_comparator_output(raw), .compare_interrupt(irq), .trigger_output(trig));
    cms_partner #(.LS_P(LS_P), .OSC_P(OSC_P)) far_end (.clk(clk), .nrst(nrst), .level(level),
        .raw_out(raw), .ls_pulse(ls_clk), .osc_pulse(osc_clk));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Interrupt pulses are counted mid-cycle, away from the launching edge.
    always @(negedge clk) begin
        if (irq === 1'b1) irq_cnt++;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == TMAX) begin
            n_errors++;
            close_out();
        end
    end

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic wait_bit(input int b, input logic v);
        int n;
        n = 0;
        rd_reg(CTRL_OFS);
        while (d[b] !== v && n < 3000) begin
            rd_reg(CTRL_OFS);
            n++;
        end
        if (d[b] !== v) begin
            n_errors++;
            $display("unexpected control bit %0d: expected %0h seen %0h", b, v, d[b]);
        end
    endtask

    initial begin
        nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0; level = 1'b0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(CTRL_OFS); `CHK("ctrl reset", ZERO_WORD, d)
        rd_reg(MODE_OFS); `CHK("mode reset", MODE_RST, d)
        wr_reg(4'h5, 16'hffff);
        rd_reg(4'h5); `CHK("unmapped read", ZERO_WORD, d)
        rd_reg(CTRL_OFS); `CHK("ctrl after unmapped write", ZERO_WORD, d)
        $display("test reset done");
        // Each supervisor run is stopped by software with a zero write to the control word.
        for (int c = 0; c < 4; c++) begin
            level <= 1'b1;
            // Codes 10 and 11 run sampled on the half-rate low clock.
            wr_reg(MODE_OFS, 16'h0020 | c[1:0] | (c[1] ? 16'h0100 : ZERO_WORD));
            k0 = irq_cnt;
            wr_reg(CTRL_OFS, 16'h0001);
            rd_reg(CTRL_OFS); `CHK("not yet valid", 1'b0, d[VLD_BIT])
            wait_bit(VLD_BIT, 1'b1);
            repeat (4) @(posedge clk);
            `CHK("start irq", k0 + c[1], irq_cnt)
            `CHK("result high", 1'b1, d[RES_BIT])
            `CHK("trigger at start", (c != 1), trig)
            level <= 1'b0;
            repeat (50) @(posedge clk);
            `CHK("fall irq", k0 + c[1] + c[0], irq_cnt)
            `CHK("trigger after fall", (c == 1), trig)
            level <= 1'b1;
            repeat (50) @(posedge clk);
            `CHK("rise irq", k0 + 2 * c[1] + c[0], irq_cnt)
            wr_reg(CTRL_OFS, ZERO_WORD);
            level <= 1'b0;
            repeat (10) @(posedge clk);
            rd_reg(CTRL_OFS); `CHK("held result", 3'h6, d[2:0])
            `CHK("trigger stopped", 1'b0, trig)
        end
        $display("test supervisor done");
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 5; i++) begin
                level <= i[0];
                wr_reg(MODE_OFS, {3'h0, set_tab[i][2], 2'h0, set_tab[i][1:0], 3'h0, m[0],
                    2'h0, i[1], 1'b1});
                k0 = irq_cnt;
                t0 = cyc;
                wr_reg(CTRL_OFS, 16'h0001);
                wait_bit(EN_BIT, 1'b0);
                t = cyc - t0;
                t_lo = n_tab[i] * p_tab[i];
                t_hi = (n_tab[i] + 1) * p_tab[i] + 8;
                `CHK("off time", 1'b1, (t >= t_lo && t <= t_hi))
                repeat (3) @(posedge clk);
                `CHK("end irq", k0 + ((m == 1) || (i[0] == i[1])), irq_cnt)
                `CHK("end word", {1'b1, i[0], 1'b0}, d[2:0])
            end
        end
        $display("test single modes done");
        wr_reg(MODE_OFS, 16'h0010);
        k0 = irq_cnt;
        wr_reg(CTRL_OFS, 16'h0001);
        wr_reg(MODE_OFS, 16'h0020);
        rd_reg(MODE_OFS); `CHK("mode locked", 16'h0010, d)
        wr_reg(CTRL_OFS, ZERO_WORD);
        repeat (4) @(posedge clk);
        `CHK("abort irq", k0 + 1, irq_cnt)
        $display("test abort done");
        close_out();
    end
endmodule
